// ==== hw/tws_map.vh ====
// register offsets, fields, status codes and timing counts of the two-wire slave transmitter
`ifndef TWS_MAP_VH
`define TWS_MAP_VH
// byte addresses of the AXI4-Lite register words
`define TWS_ADDR_DATA       4'h0
`define TWS_ADDR_STATUS     4'h4
`define TWS_ADDR_CONTROL    4'h8
`define TWS_ADDR_OWN        4'hC
// control register fields
`define TWS_CTL_DONE        7
`define TWS_CTL_ACK_EN      6
`define TWS_CTL_START       5
`define TWS_CTL_STOP        4
`define TWS_CTL_ENABLE      2
`define TWS_CTL_RESET       8'h00
`define TWS_OWN_RESET       8'h00
`define TWS_DATA_RESET      8'hFF
// status codes, prescaler bits always zero
`define TWS_ST_SLA_R_ACK    8'hA8
`define TWS_ST_ARB_SLA_R    8'hB0
`define TWS_ST_DATA_ACK     8'hB8
`define TWS_ST_DATA_NACK    8'hC0
`define TWS_ST_LAST_ACK     8'hC8
`define TWS_ST_IDLE         8'hF8
`define TWS_ST_BUS_ERR      8'h00
`define TWS_GC_ADDR         7'h00
// data hold after falling clock edge
`define TWS_HOLD_NS         300
`define TWS_CLK_NS          4
`define TWS_HOLD_CYC        ((`TWS_HOLD_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`endif

// ==== hw/tws_sync.v ====
// two-flip-flop synchroniser with edge and bus condition detection for the two wire lines
`timescale 1ns/1ps
module tws_sync (
	input  wire mclk,
	input  wire rst,
	input  wire scl_i,
	input  wire sda_i,
	output reg  scl_s,
	output reg  sda_s,
	output wire scl_rise,
	output wire scl_fall,
	output wire start_det,
	output wire stop_det
);
	reg scl_m_reg;
	reg sda_m_reg;
	reg scl_d_reg;
	reg sda_d_reg;

	// first stage feeds only the second stage
	always @(posedge mclk) begin
		if (rst) begin
			scl_m_reg <= 1'b1;
			sda_m_reg <= 1'b1;
			scl_s     <= 1'b1;
			sda_s     <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_m_reg <= scl_i;
			sda_m_reg <= sda_i;
			scl_s     <= scl_m_reg;
			sda_s     <= sda_m_reg;
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// edges and start/stop while clock is high
	assign scl_rise  = scl_s & ~scl_d_reg;
	assign scl_fall  = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
endmodule

// ==== hw/tws_top.v ====
// two-wire slave transmitter with status codes and an AXI4-Lite register port
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tws_map.vh"
module tws_top #(
	parameter HOLD_CYC = `TWS_HOLD_CYC
) (
	input  wire        mclk,
	input  wire        rst,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        arb_lost,
	input  wire        scl_i,
	output wire        scl_o,
	output reg         scl_oe,
	input  wire        sda_i,
	output wire        sda_o,
	output reg         sda_oe,
	output reg         start_pending
);
	localparam S_IDLE = 3'd0;
	localparam S_ADDR = 3'd1;
	localparam S_AACK = 3'd2;
	localparam S_WAIT = 3'd3;
	localparam S_SEND = 3'd4;
	localparam S_MACK = 3'd5;
	localparam S_SKIP = 3'd6;

	wire       scl_s;
	wire       sda_s;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_det;
	wire       stop_det;
	reg  [2:0] state_reg;
	reg  [3:0] bit_reg;
	reg  [7:0] shift_reg;
	reg  [7:0] serial_data_register;
	reg  [7:0] own_address_register;
	reg  [7:0] status_reg;
	reg        transfer_done_flag;
	reg        ack_enable;
	reg        start_request;
	reg        stop_request;
	reg        enable_reg;
	reg        last_reg;
	reg        arb_reg;
	reg        busy_reg;
	reg [15:0] hold_reg;
	reg        aw_got_reg;
	reg        w_got_reg;
	reg  [3:0] aw_addr_reg;
	reg  [7:0] w_data_reg;
	reg        w_lane_reg;

	tws_sync u_sync (
		.mclk      (mclk),
		.rst       (rst),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.scl_s     (scl_s),
		.sda_s     (sda_s),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	// open-drain lines only ever pull low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;

	// address match on own address or enabled general call
	function addr_hit;
		input [6:0] a;
		input [7:0] own;
		begin
			addr_hit = (a == own[7:1]) || (own[0] && a == `TWS_GC_ADDR);
		end
	endfunction

	// write channel handshake: each address/data taken once, either order
	assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_got_reg & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	wire wr_go = aw_got_reg & w_got_reg & ~s_axi_bvalid;
	wire wr_ctl = wr_go && aw_addr_reg == `TWS_ADDR_CONTROL && w_lane_reg;
	wire flag_clear = wr_ctl && w_data_reg[`TWS_CTL_DONE];
	wire in_xfer = state_reg != S_IDLE && state_reg != S_ADDR;

	// axi write capture and response
	always @(posedge mclk) begin
		if (rst) begin
			aw_got_reg   <= 1'b0;
			w_got_reg    <= 1'b0;
			aw_addr_reg  <= 4'h0;
			w_data_reg   <= 8'h00;
			w_lane_reg   <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg  <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg  <= 1'b1;
				w_data_reg <= s_axi_wdata[7:0];
				w_lane_reg <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_got_reg   <= 1'b0;
				w_got_reg    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr_reg[1:0] != 2'b00 || aw_addr_reg == `TWS_ADDR_STATUS)
					s_axi_bresp <= 2'b10;
				else
					s_axi_bresp <= 2'b00;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// axi read answer; status shows F8 whenever flag is clear
	always @(posedge mclk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'b00;
			if (s_axi_araddr == `TWS_ADDR_DATA)
				s_axi_rdata <= {24'h000000, serial_data_register};
			else if (s_axi_araddr == `TWS_ADDR_STATUS)
				s_axi_rdata <= {24'h000000, transfer_done_flag ? status_reg : `TWS_ST_IDLE};
			else if (s_axi_araddr == `TWS_ADDR_CONTROL)
				s_axi_rdata <= {24'h000000, transfer_done_flag, ack_enable, start_request, stop_request,
					1'b0, enable_reg, 2'b00};
			else if (s_axi_araddr == `TWS_ADDR_OWN)
				s_axi_rdata <= {24'h000000, own_address_register};
			else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= 2'b10;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// hold counter spaces data changes from the falling clock edge
	always @(posedge mclk) begin
		if (rst)
			hold_reg <= 16'h0000;
		else if (scl_fall)
			hold_reg <= HOLD_CYC[15:0];
		else if (hold_reg != 16'h0000)
			hold_reg <= hold_reg - 16'h0001;
	end

	// bus free tracking and pending START after leaving C0/C8
	always @(posedge mclk) begin
		if (rst) begin
			busy_reg      <= 1'b0;
			start_pending <= 1'b0;
		end else begin
			if (start_det)
				busy_reg <= 1'b1;
			else if (stop_det)
				busy_reg <= 1'b0;
			if (flag_clear && w_data_reg[`TWS_CTL_START]
				&& (status_reg == `TWS_ST_DATA_NACK || status_reg == `TWS_ST_LAST_ACK))
				start_pending <= 1'b1;
			else if (start_pending && !busy_reg && !start_det)
				start_pending <= 1'b0;
		end
	end

	// slave transmitter state machine with registers
	always @(posedge mclk) begin
		if (rst) begin
			state_reg            <= S_IDLE;
			bit_reg              <= 4'd0;
			shift_reg            <= 8'h00;
			serial_data_register <= `TWS_DATA_RESET;
			own_address_register <= `TWS_OWN_RESET;
			status_reg           <= `TWS_ST_IDLE;
			transfer_done_flag   <= 1'b0;
			{ack_enable, start_request, stop_request, enable_reg} <= 4'b0000;
			last_reg             <= 1'b0;
			arb_reg              <= 1'b0;
			sda_oe               <= 1'b0;
			scl_oe               <= 1'b0;
		end else begin
			if (wr_go && w_lane_reg && aw_addr_reg == `TWS_ADDR_DATA)
				serial_data_register <= w_data_reg;
			if (wr_go && w_lane_reg && aw_addr_reg == `TWS_ADDR_OWN)
				own_address_register <= w_data_reg;
			if (arb_lost)
				arb_reg <= 1'b1;
			if (wr_ctl) begin
				ack_enable    <= w_data_reg[`TWS_CTL_ACK_EN];
				start_request <= w_data_reg[`TWS_CTL_START];
				stop_request  <= w_data_reg[`TWS_CTL_STOP];
				enable_reg    <= w_data_reg[`TWS_CTL_ENABLE];
			end
			// clock held low while the flag waits in a transfer
			scl_oe <= transfer_done_flag && in_xfer;
			if (flag_clear)
				transfer_done_flag <= 1'b0;
			if (!enable_reg) begin
				state_reg <= S_IDLE;
				sda_oe    <= 1'b0;
			end else if ((start_det || stop_det) && (state_reg == S_ADDR || state_reg == S_SEND)
				&& bit_reg != 4'd0) begin
				state_reg          <= S_IDLE;
				status_reg         <= `TWS_ST_BUS_ERR;
				transfer_done_flag <= 1'b1;
				sda_oe             <= 1'b0;
			end else if ((start_det || stop_det) && (state_reg == S_AACK || state_reg == S_MACK)) begin
				state_reg          <= S_IDLE;
				status_reg         <= `TWS_ST_BUS_ERR;
				transfer_done_flag <= 1'b1;
				sda_oe             <= 1'b0;
			end else if (flag_clear && status_reg == `TWS_ST_BUS_ERR && w_data_reg[`TWS_CTL_STOP]) begin
				state_reg    <= S_IDLE;
				stop_request <= 1'b0;
				sda_oe       <= 1'b0;
			end else if (start_det) begin
				state_reg <= S_ADDR;
				bit_reg   <= 4'd0;
				sda_oe    <= 1'b0;
			end else if (stop_det) begin
				state_reg <= S_IDLE;
				sda_oe    <= 1'b0;
			end else begin
				case (state_reg)
				S_IDLE: begin
					sda_oe <= 1'b0;
				end
				S_ADDR: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_s};
						bit_reg   <= bit_reg + 4'd1;
					end
					if (bit_reg == 4'd8 && scl_fall) begin
						bit_reg <= 4'd0;
						// ack only a read to own address or enabled general call while ack enable is set
						if (ack_enable && shift_reg[0] && addr_hit(shift_reg[7:1], own_address_register)) begin
							state_reg <= S_AACK;
							sda_oe    <= 1'b1;
						end else begin
							state_reg <= S_IDLE;
						end
					end
				end
				S_AACK: begin
					if (scl_fall) begin
						sda_oe             <= 1'b0;
						transfer_done_flag <= 1'b1;
						status_reg         <= arb_reg ? `TWS_ST_ARB_SLA_R : `TWS_ST_SLA_R_ACK;
						arb_reg            <= 1'b0;
						state_reg          <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (flag_clear) begin
						// ack enable at release chooses last byte or not
						last_reg  <= ~w_data_reg[`TWS_CTL_ACK_EN];
						shift_reg <= serial_data_register;
						bit_reg   <= 4'd0;
						state_reg <= S_SEND;
					end
				end
				S_SEND: begin
					if (hold_reg == 16'h0001 || (bit_reg == 4'd0 && !scl_s)) begin
						sda_oe <= ~shift_reg[7];
					end
					if (scl_fall) begin
						shift_reg <= {shift_reg[6:0], 1'b1};
						bit_reg   <= bit_reg + 4'd1;
						if (bit_reg == 4'd7) begin
							state_reg <= S_MACK;
							bit_reg   <= 4'd0;
						end
					end
				end
				S_MACK: begin
					if (hold_reg == 16'h0001)
						sda_oe <= 1'b0;
					if (scl_rise) begin
						shift_reg[0] <= sda_s;
						bit_reg      <= 4'd1;
					end
					if (scl_fall && bit_reg == 4'd1) begin // flag on the fall: stretch starts with clock low
						transfer_done_flag <= 1'b1;
						if (shift_reg[0]) begin
							status_reg <= `TWS_ST_DATA_NACK;
							state_reg  <= S_SKIP;
						end else if (last_reg) begin
							status_reg <= `TWS_ST_LAST_ACK;
							state_reg  <= S_SKIP;
						end else begin
							status_reg <= `TWS_ST_DATA_ACK;
							state_reg  <= S_WAIT;
						end
					end
				end
				S_SKIP: begin
					sda_oe <= 1'b0;
					if (flag_clear) begin
						ack_enable <= w_data_reg[`TWS_CTL_ACK_EN];
						state_reg  <= S_IDLE;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
				endcase
			end
		end
	end
endmodule

// ==== dv/tws_sva.sv ====
// port assertions for the two-wire slave transmitter
`timescale 1ns/1ps
module tws_sva (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [3:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        scl_oe,
	input wire logic        sda_oe,
	input wire logic        start_pending
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// write steps on the register port
	sequence s_aw_w;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_clear_write;
		s_aw_w ##0 (s_axi_awaddr == 4'h8 && s_axi_wdata[7]);
	endsequence
	sequence s_status_write;
		s_aw_w ##0 (s_axi_awaddr == 4'h4);
	endsequence
	property p_reset_idle;
		$fell(rst) |-> !scl_oe && !sda_oe && !start_pending;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("line or start active after reset");
	property p_stretch_release;
		scl_oe ##0 s_clear_write |-> ##[1:3] !scl_oe;
	endproperty
	a_stretch_release: assert property (p_stretch_release) else $error("clock not released");
	property p_status_err;
		s_status_write |-> ##[1:3] (s_axi_bvalid && s_axi_bresp == 2'h2);
	endproperty
	a_status_err: assert property (p_status_err) else $error("status write not refused");
	property p_write_answer;
		s_aw_w |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write answer late");
	property p_read_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer late");
	property p_ar_refused;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_refused: assert property (p_ar_refused) else $error("read taken while answer pending");
	property p_aw_refused;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_refused: assert property (p_aw_refused) else $error("write taken while answer pending");
	property p_upper_zero;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
endmodule
bind tws_top tws_sva u_sva (.mclk(mclk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .scl_oe(scl_oe), .sda_oe(sda_oe), .start_pending(start_pending));

// ==== dv/tws_master_model.sv ====
// behavioural bus master acting as receiver
`timescale 1ns/1ps
module tws_master_model (
	input  wire  scl,
	input  wire  sda,
	output logic scl_m,
	output logic sda_m
);
	// lines released, idle high
	initial begin
		scl_m = 1;
		sda_m = 1;
	end
	// release clock, wait out stretching
	task high;
		#30 scl_m = 1;
		wait (scl === 1'b1);
	endtask
	task start;
		sda_m = 1;
		high;
		#20 sda_m = 0;
		#20 scl_m = 0;
	endtask
	task stop;
		#10 sda_m = 0;
		high;
		#20 sda_m = 1;
		#40;
	endtask
	task put_bits(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			#10 sda_m = b[7-i];
			high;
			#40 scl_m = 0;
		end
	endtask
	task get_bit(output logic v);
		#10 sda_m = 1;
		high;
		#20 v = sda;
		#20 scl_m = 0;
	endtask
	task put_byte(input logic [7:0] b, output logic ack);
		put_bits(b, 8);
		get_bit(ack);
	endtask
	task get_byte(output logic [7:0] d, input logic nack);
		logic v;
		for (int i = 0; i < 8; i++) begin
			get_bit(v);
			d[7-i] = v;
		end
		#10 sda_m = nack;
		high;
		#40 scl_m = 0;
	endtask
endmodule

// ==== dv/tws_tb_top.sv ====
// self-checking bench for the two-wire slave transmitter
`timescale 1ns/1ps
`include "tws_map.vh"
module tws_tb_top;
	logic        mclk, rst, arb_lost, awvalid, wvalid, bready, arvalid, rready, ack;
	logic [3:0]  awaddr, araddr;
	logic [31:0] wdata, rd;
	logic [7:0]  got;
	logic [1:0]  bresp_s;
	wire         awready, wready, bvalid, arready, rvalid, scl_o, sda_o, scl_oe, sda_oe, pend, scl_m, sda_m;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire         scl_w = scl_m & ~(scl_oe & ~scl_o);
	wire         sda_w = sda_m & ~(sda_oe & ~sda_o);
	int          n_mismatch, check_count;
	tws_top #(.HOLD_CYC(2)) dut_u (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .arb_lost(arb_lost),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
		.start_pending(pend));
	tws_master_model m_u (.scl(scl_w), .sda(sda_w), .scl_m(scl_m), .sda_m(sda_m));
	initial begin
		mclk = 0;
		forever #2 mclk = ~mclk;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// register port master
	task axi_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		forever begin
			@(posedge mclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) break;
		end
		bresp_s = bresp;
		bready <= 0;
	endtask
	task axi_rd(input logic [3:0] a);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		forever begin
			@(posedge mclk);
			if (arready) arvalid <= 0;
			if (rvalid) break;
		end
		rd = rdata;
		rready <= 0;
	endtask
	task rd_chk(input logic [3:0] a, input logic [31:0] e, input string nm);
		axi_rd(a);
		chk(nm, rd, e);
	endtask
	// poll status until the flag shows a code
	task wait_code(input logic [7:0] e, input string nm);
		for (int n = 0; n < 500; n++) begin
			axi_rd(`TWS_ADDR_STATUS);
			if (rd[7:0] !== 8'hF8) break;
		end
		chk(nm, rd & 32'hF8, {24'h0, e});
	endtask
	task addr(input logic nack);
		m_u.start;
		m_u.put_byte(8'hA1, ack);
		chk("address ack", ack, nack);
	endtask
	task send(input logic [7:0] b, input logic [7:0] c, input logic nack);
		fork
			m_u.get_byte(got, nack);
			begin
				axi_wr(`TWS_ADDR_DATA, b);
				axi_wr(`TWS_ADDR_CONTROL, c);
				rd_chk(`TWS_ADDR_STATUS, 32'hF8, "status in byte");
			end
		join
		chk("byte on bus", got, b);
	endtask
	task t_regs;
		rd_chk(`TWS_ADDR_DATA, 32'hFF, "data reset");
		rd_chk(`TWS_ADDR_STATUS, 32'hF8, "status idle");
		rd_chk(`TWS_ADDR_CONTROL, 32'h0, "control reset");
		rd_chk(`TWS_ADDR_OWN, 32'h0, "own reset");
		axi_wr(`TWS_ADDR_STATUS, 8'h55);
		chk("status write resp", bresp_s, 2'h2);
		axi_wr(4'h2, 8'h11);
		chk("unaligned write resp", bresp_s, 2'h2);
		rd_chk(4'h1, 32'h0, "unaligned read data");
		axi_wr(`TWS_ADDR_OWN, 8'hA0);
		axi_wr(`TWS_ADDR_CONTROL, 8'h44);
		rd_chk(`TWS_ADDR_OWN, 32'hA0, "own address");
	endtask
	task t_read;
		addr(0);
		wait_code(8'hA8, "own read");
		chk("clock held", scl_oe, 1);
		send(8'hA5, 8'hC4, 0);
		wait_code(8'hB8, "byte acked");
		send(8'h3C, 8'h84, 1);
		wait_code(8'hC0, "byte nacked");
		axi_wr(`TWS_ADDR_CONTROL, 8'h84);
		m_u.stop;
		addr(1);
		m_u.stop;
	endtask
	task t_last;
		axi_wr(`TWS_ADDR_CONTROL, 8'h44);
		addr(0);
		wait_code(8'hA8, "own read again");
		send(8'h5A, 8'h84, 0);
		wait_code(8'hC8, "last acked");
		axi_wr(`TWS_ADDR_CONTROL, 8'hE4);
		for (int n = 0; n < 10 && pend !== 1'b1; n++) @(posedge mclk);
		chk("start pending", pend, 1);
		m_u.get_byte(got, 1);
		chk("released data", got, 8'hFF);
		m_u.stop;
		for (int n = 0; n < 200 && pend !== 1'b0; n++) @(posedge mclk);
		chk("start issued", pend, 0);
	endtask
	task t_arb;
		axi_wr(`TWS_ADDR_CONTROL, 8'h44);
		arb_lost <= 1;
		@(posedge mclk);
		arb_lost <= 0;
		addr(0);
		wait_code(8'hB0, "lost arbitration");
		send(8'hC3, 8'h84, 1);
		wait_code(8'hC0, "final nack");
		axi_wr(`TWS_ADDR_CONTROL, 8'hC4);
		m_u.stop;
	endtask
	task t_err;
		m_u.start;
		m_u.put_bits(8'hA1, 3);
		m_u.start;
		wait_code(8'h00, "bus error");
		axi_wr(`TWS_ADDR_CONTROL, 8'hD4);
		rd_chk(`TWS_ADDR_CONTROL, 32'h44, "recovery control");
		rd_chk(`TWS_ADDR_STATUS, 32'hF8, "recovery status");
		chk("lines released", {scl_oe, sda_oe}, 0);
		m_u.stop;
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// main sequence
	initial begin
		{rst, arb_lost, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
		{awaddr, araddr, wdata} = 40'h0;
		repeat (20) @(posedge mclk);
		rst <= 0;
		t_regs;
		t_read;
		t_last;
		t_arb;
		t_err;
		complete_run;
	end
	// watchdog
	initial begin
		#200000;
		n_mismatch++;
		complete_run;
	end
endmodule
